// >>> core/lcd_bias_pkg.sv
// shared types and constants for the display bias power sequencer
package lcd_bias_pkg;

  // ==========================================================
  // timing
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned CHECK_TIME_NS = 1000000;
  localparam int unsigned CHECK_CYCLES = CHECK_TIME_NS / CLK_PERIOD_NS;
  localparam int TIMER_W = 16;
  localparam logic [TIMER_W-1:0] TIMER_ZERO = 16'h0000;
  localparam logic [TIMER_W-1:0] TIMER_ONE = 16'h0001;

  // ==========================================================
  // positive pump soft-start ramp
  localparam int LEVEL_W = 8;
  localparam logic [LEVEL_W-1:0] LEVEL_ZERO = 8'h00;
  localparam logic [LEVEL_W-1:0] LEVEL_FULL = 8'hFF;
  localparam logic [LEVEL_W-1:0] LEVEL_STEP = 8'h01;

  // ==========================================================
  // sequencer states
  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_BUCK_UP = 3'b001,
    ST_RESET_PULSE = 3'b010,
    ST_NEG_DELAY = 3'b011,
    ST_GATE_CHECK = 3'b100,
    ST_RUN = 3'b101,
    ST_FAULT = 3'b110
  } seq_state_t;

  // ==========================================================
  // analog comparator and pin levels, all asynchronous to ref_clk
  typedef struct packed {
    logic supply_above_uvlo;
    logic temp_above_hot;
    logic temp_below_cool;
    logic buck_power_good;
    logic reset_timing_input;
    logic source_rail_near_vin;
    logic positive_pump_feedback_ok;
  } sense_t;

  // ==========================================================
  // rail and pin controls
  typedef struct packed {
    logic buck_enable;
    logic panel_reset_n_out;
    logic panel_reset_n_oe;
    logic neg_pump_enable;
    logic isolation_gate_drive_n;
    logic pos_pump_short_mode;
    logic pos_pump_current_off;
    logic pos_pump_normal;
    logic [LEVEL_W-1:0] positive_pump_control;
    logic boost_enable;
    logic source_rail_error;
    logic thermal_shutdown;
  } rail_ctrl_t;

  localparam rail_ctrl_t CTRL_RESET = '{
    buck_enable: 1'b0,
    panel_reset_n_out: 1'b0,
    panel_reset_n_oe: 1'b1,
    neg_pump_enable: 1'b0,
    isolation_gate_drive_n: 1'b1,
    pos_pump_short_mode: 1'b0,
    pos_pump_current_off: 1'b0,
    pos_pump_normal: 1'b0,
    positive_pump_control: 8'h00,
    boost_enable: 1'b0,
    source_rail_error: 1'b0,
    thermal_shutdown: 1'b0
  };

endpackage : lcd_bias_pkg

// >>> core/lcd_bias_power_sequencer.sv
// start-up sequencer for a four-rail display bias supply
// Functional notes
// (RULE_01) buck after uvlo release; rails come up in order
// (RULE_02) buck power-good starts reset timer, then release
// (RULE_03) rail delay starts with negative pump enable
// (RULE_04) below uvlo every rail off at once
// (RULE_05) gate drive low after rail delay elapses
// (RULE_06) check source rail exactly 1ms after gate
// (RULE_07) source rail short at check: error, no boost
// (RULE_08) positive pump short mode with gate low
// (RULE_09) feedback 100mV reached: stop pump current temporarily
// (RULE_10) boost switching: pump normal with soft-start ramp
// (RULE_11) open-drain active-low reset held during pulse
// (RULE_12) reset pin level never blocks the sequence
// (RULE_13) zero reset time passes straight through
// (RULE_14) external enable mode holds reset and pump
// (RULE_15) thermal shutdown above hot, resume when cool
// (RULE_16) reset and rail delay are programmable counters
module lcd_bias_power_sequencer #(
  parameter logic [15:0] CHECK_TIME_CYCLES = 16'(lcd_bias_pkg::CHECK_CYCLES)
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // configuration, same clock domain
  input wire logic [15:0] reset_time_cycles,
  input wire logic [15:0] rail_delay_time,
  input wire logic ext_enable_mode,
  // comparator and pin levels
  input wire lcd_bias_pkg::sense_t sense,
  // rail controls
  output lcd_bias_pkg::rail_ctrl_t ctrl
);

  // ==========================================================
  // input synchronisers
  lcd_bias_pkg::sense_t sense_s1_ff;
  lcd_bias_pkg::sense_t sense_s2_ff;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sense_s1_ff <= '0;
      sense_s2_ff <= '0;
    end else begin
      sense_s1_ff <= sense;
      sense_s2_ff <= sense_s1_ff;
    end
  end

  // ==========================================================
  // thermal hysteresis
  logic hot_ff;
  logic nxt_hot;

  always_comb begin
    nxt_hot = hot_ff;
    if (sense_s2_ff.temp_above_hot) begin
      nxt_hot = 1'b1; // see (RULE_15)
    end else if (sense_s2_ff.temp_below_cool) begin
      nxt_hot = 1'b0; // see (RULE_15)
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      hot_ff <= 1'b0;
    end else begin
      hot_ff <= nxt_hot;
    end
  end

  // ==========================================================
  // sequencer
  lcd_bias_pkg::seq_state_t state_ff;
  lcd_bias_pkg::seq_state_t nxt_state;
  logic [15:0] timer_ff;
  logic [15:0] nxt_timer;
  logic [7:0] level_ff;
  logic [7:0] nxt_level;
  logic inhibit;

  function automatic logic reached(input logic [15:0] cnt, input logic [15:0] lim);
    reached = (lim == lcd_bias_pkg::TIMER_ZERO) || (cnt >= lim - lcd_bias_pkg::TIMER_ONE);
  endfunction : reached

  // no ordered power-down: any inhibit drops straight to off
  assign inhibit = !sense_s2_ff.supply_above_uvlo || nxt_hot; // see (RULE_04) see (RULE_15)

  always_comb begin
    nxt_state = state_ff;
    nxt_timer = timer_ff + lcd_bias_pkg::TIMER_ONE;
    nxt_level = level_ff;
    if (inhibit) begin
      nxt_state = lcd_bias_pkg::ST_OFF; // see (RULE_04)
      nxt_timer = lcd_bias_pkg::TIMER_ZERO;
      nxt_level = lcd_bias_pkg::LEVEL_ZERO;
    end else begin
      case (state_ff)
        lcd_bias_pkg::ST_OFF: begin
          nxt_state = lcd_bias_pkg::ST_BUCK_UP; // see (RULE_01)
          nxt_timer = lcd_bias_pkg::TIMER_ZERO;
        end
        lcd_bias_pkg::ST_BUCK_UP: begin
          nxt_timer = lcd_bias_pkg::TIMER_ZERO;
          if (sense_s2_ff.buck_power_good) begin
            nxt_state = lcd_bias_pkg::ST_RESET_PULSE; // see (RULE_02) see (RULE_16)
          end
        end
        lcd_bias_pkg::ST_RESET_PULSE: begin
          // reset pin is output only, so its wiring cannot stall this
          if (ext_enable_mode) begin
            if (sense_s2_ff.reset_timing_input) begin
              nxt_state = lcd_bias_pkg::ST_NEG_DELAY; // see (RULE_14) see (RULE_12)
              nxt_timer = lcd_bias_pkg::TIMER_ZERO;
            end
          end else if (reached(timer_ff, reset_time_cycles)) begin
            nxt_state = lcd_bias_pkg::ST_NEG_DELAY; // see (RULE_02) see (RULE_13)
            nxt_timer = lcd_bias_pkg::TIMER_ZERO; // see (RULE_03) see (RULE_16)
          end
        end
        lcd_bias_pkg::ST_NEG_DELAY: begin
          if (reached(timer_ff, rail_delay_time)) begin
            nxt_state = lcd_bias_pkg::ST_GATE_CHECK; // see (RULE_05) see (RULE_03)
            nxt_timer = lcd_bias_pkg::TIMER_ZERO;
          end
        end
        lcd_bias_pkg::ST_GATE_CHECK: begin
          if (reached(timer_ff, CHECK_TIME_CYCLES)) begin
            nxt_timer = lcd_bias_pkg::TIMER_ZERO;
            if (sense_s2_ff.source_rail_near_vin) begin
              nxt_state = lcd_bias_pkg::ST_RUN; // see (RULE_06)
            end else begin
              nxt_state = lcd_bias_pkg::ST_FAULT; // see (RULE_07)
            end
          end
        end
        lcd_bias_pkg::ST_RUN: begin
          nxt_timer = lcd_bias_pkg::TIMER_ZERO;
          if (level_ff != lcd_bias_pkg::LEVEL_FULL) begin
            nxt_level = level_ff + lcd_bias_pkg::LEVEL_STEP; // see (RULE_10)
          end
        end
        default: begin
          nxt_timer = lcd_bias_pkg::TIMER_ZERO;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_ff <= lcd_bias_pkg::ST_OFF;
      timer_ff <= lcd_bias_pkg::TIMER_ZERO;
      level_ff <= lcd_bias_pkg::LEVEL_ZERO;
    end else begin
      state_ff <= nxt_state;
      timer_ff <= nxt_timer;
      level_ff <= nxt_level;
    end
  end

  // ==========================================================
  // registered outputs, decoded from the next state
  lcd_bias_pkg::rail_ctrl_t nxt_ctrl;
  logic past_neg;
  logic past_gate;

  always_comb begin
    nxt_ctrl = lcd_bias_pkg::CTRL_RESET;
    past_gate = (nxt_state == lcd_bias_pkg::ST_GATE_CHECK) ||
                (nxt_state == lcd_bias_pkg::ST_RUN) || (nxt_state == lcd_bias_pkg::ST_FAULT);
    past_neg = (nxt_state == lcd_bias_pkg::ST_NEG_DELAY) || past_gate;
    nxt_ctrl.thermal_shutdown = nxt_hot;
    nxt_ctrl.buck_enable = (nxt_state != lcd_bias_pkg::ST_OFF); // see (RULE_01)
    nxt_ctrl.panel_reset_n_oe = !past_neg; // see (RULE_11)
    nxt_ctrl.neg_pump_enable = past_neg; // see (RULE_02)
    nxt_ctrl.isolation_gate_drive_n = !past_gate; // see (RULE_05)
    nxt_ctrl.pos_pump_short_mode = (nxt_state == lcd_bias_pkg::ST_GATE_CHECK) ||
                                   (nxt_state == lcd_bias_pkg::ST_FAULT); // see (RULE_08)
    nxt_ctrl.pos_pump_current_off = nxt_ctrl.pos_pump_short_mode &&
                                    sense_s2_ff.positive_pump_feedback_ok; // see (RULE_09)
    nxt_ctrl.boost_enable = (nxt_state == lcd_bias_pkg::ST_RUN); // see (RULE_06)
    nxt_ctrl.pos_pump_normal = nxt_ctrl.boost_enable; // see (RULE_10)
    nxt_ctrl.positive_pump_control = nxt_level; // see (RULE_10)
    nxt_ctrl.source_rail_error = (nxt_state == lcd_bias_pkg::ST_FAULT); // see (RULE_07)
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ctrl <= lcd_bias_pkg::CTRL_RESET;
    end else begin
      ctrl <= nxt_ctrl;
    end
  end

  // ==========================================================
  // checks
  a_rail_order: assert property (@(posedge ref_clk) disable iff (reset) // see (RULE_01)
    ctrl.boost_enable |-> ctrl.neg_pump_enable && ctrl.buck_enable)
    else $error("boost on before lower rails");

  a_reset_release: assert property (@(posedge ref_clk) disable iff (reset) // see (RULE_02)
    $rose(ctrl.neg_pump_enable) |-> !ctrl.panel_reset_n_oe && $past(ctrl.panel_reset_n_oe))
    else $error("negative pump not tied to reset release");

  a_delay_gate: assert property (@(posedge ref_clk) disable iff (reset) // see (RULE_05)
    $fell(ctrl.isolation_gate_drive_n) |-> $past(state_ff) == lcd_bias_pkg::ST_NEG_DELAY)
    else $error("gate drive fell outside rail delay");

  a_uvlo_off: assert property (@(posedge ref_clk) disable iff (reset) // see (RULE_04)
    !sense_s2_ff.supply_above_uvlo |=> !ctrl.buck_enable && !ctrl.neg_pump_enable &&
      !ctrl.boost_enable && ctrl.isolation_gate_drive_n)
    else $error("rails not dropped under uvlo");

  a_check_time: assert property (@(posedge ref_clk) disable iff (reset) // see (RULE_06)
    $rose(ctrl.boost_enable) |-> $past(state_ff) == lcd_bias_pkg::ST_GATE_CHECK &&
      $past(timer_ff) == CHECK_TIME_CYCLES - lcd_bias_pkg::TIMER_ONE &&
      $past(sense_s2_ff.source_rail_near_vin))
    else $error("boost enabled off the check instant");

  a_error_blocks: assert property (@(posedge ref_clk) disable iff (reset) // see (RULE_07)
    ctrl.source_rail_error |-> !ctrl.boost_enable && !ctrl.isolation_gate_drive_n)
    else $error("boost on with source rail error");

  a_short_gate: assert property (@(posedge ref_clk) disable iff (reset) // see (RULE_08)
    !ctrl.isolation_gate_drive_n |-> ctrl.pos_pump_short_mode != ctrl.boost_enable)
    else $error("pump mode wrong with gate low");

  a_thermal_off: assert property (@(posedge ref_clk) disable iff (reset) // see (RULE_15)
    sense_s2_ff.temp_above_hot |=> ctrl.thermal_shutdown && !ctrl.buck_enable)
    else $error("thermal shutdown missed");

  a_zero_reset: assert property (@(posedge ref_clk) disable iff (reset) // see (RULE_13)
    state_ff == lcd_bias_pkg::ST_RESET_PULSE && reset_time_cycles == lcd_bias_pkg::TIMER_ZERO &&
      !ext_enable_mode && !inhibit |=> state_ff == lcd_bias_pkg::ST_NEG_DELAY)
    else $error("zero reset time did not pass through");

endmodule : lcd_bias_power_sequencer

// >>> sim/far_side_model.sv
// behavioural converters and panel side facing the bias sequencer
module far_side_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // device controls and bench levers
  input wire lcd_bias_pkg::rail_ctrl_t ctrl,
  input wire logic supply_ok,
  input wire logic hot,
  input wire logic cool,
  input wire logic enable_level,
  input wire logic src_fail,
  // comparator levels back to the device
  output lcd_bias_pkg::sense_t sense
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] buck_ff;
  logic [3:0] src_ff;
  logic [1:0] fbp_ff;
  // ==========================================================
  // rails settle a few cycles after their enables and drop the same few cycles after release
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      buck_ff <= 3'h0;
      src_ff <= 4'h0;
      fbp_ff <= 2'h0;
    end else begin
      buck_ff <= {buck_ff[1:0], ctrl.buck_enable};
      src_ff <= {src_ff[2:0], ~ctrl.isolation_gate_drive_n & ~src_fail};
      fbp_ff <= {fbp_ff[0], ctrl.pos_pump_short_mode};
    end
  end
  // external enable level drives the reset timing input
  assign sense = '{supply_above_uvlo: supply_ok, temp_above_hot: hot, temp_below_cool: cool,
                   buck_power_good: buck_ff[2], reset_timing_input: enable_level,
                   source_rail_near_vin: src_ff[3], positive_pump_feedback_ok: fbp_ff[1]};
endmodule : far_side_model

// >>> sim/tb_top.sv
// self-checking bench for the display bias power sequencer
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // stimulus and wiring
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [15:0] reset_time_cycles = 16'h0005;
  logic [15:0] rail_delay_time = 16'h0003;
  logic ext_enable_mode = 1'b0;
  logic supply_ok = 1'b0;
  logic hot = 1'b0;
  logic cool = 1'b1;
  logic enable_level = 1'b0;
  logic src_fail = 1'b0;
  lcd_bias_pkg::sense_t sense;
  lcd_bias_pkg::rail_ctrl_t ctrl;
  int fails = 0;
  int comparisons = 0;
  int n;
  int t1;
  always #12.5 ref_clk = ~ref_clk;
  // short gate check keeps the run brief
  lcd_bias_power_sequencer #(.CHECK_TIME_CYCLES(16'h0010)) u_lcd_bias_power_sequencer (
    .ref_clk(ref_clk), .reset(reset), .reset_time_cycles(reset_time_cycles),
    .rail_delay_time(rail_delay_time), .ext_enable_mode(ext_enable_mode),
    .sense(sense), .ctrl(ctrl));
  far_side_model u_far_side_model (
    .ref_clk(ref_clk), .reset(reset), .ctrl(ctrl), .supply_ok(supply_ok), .hot(hot),
    .cool(cool), .enable_level(enable_level), .src_fail(src_fail), .sense(sense));
  // ==========================================================
  // shared tasks
  task automatic give_verdict();
    if (fails == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : give_verdict
  task automatic check_bit(input logic got, input logic exp, input string what);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %0t %s", $time, what);
    end
  endtask : check_bit
  task automatic check_num(input int got, input int exp, input string what);
    comparisons++;
    if (got != exp) begin
      fails++;
      $display("mismatch %0t %s got %0d", $time, what, got);
    end
  endtask : check_num
  function automatic logic pick(input int k);
    case (k)
      0: return ctrl.buck_enable;
      1: return ctrl.neg_pump_enable;
      2: return ctrl.isolation_gate_drive_n;
      3: return ctrl.boost_enable;
      default: return ctrl.source_rail_error;
    endcase
  endfunction : pick
  // counts edges until the chosen output reaches the level; bounded
  task automatic wait_for(input int k, input logic v, output int cnt);
    cnt = 0;
    while (pick(k) !== v) begin
      @(posedge ref_clk);
      #1;
      cnt++;
      if (cnt > 2000) begin
        fails++;
        $display("mismatch %0t wait timed out", $time);
        give_verdict();
      end
    end
  endtask : wait_for
  task automatic start(input logic [15:0] r, input logic [15:0] d, input logic ext,
                       input logic fail);
    @(posedge ref_clk);
    reset <= 1'b1;
    reset_time_cycles <= r;
    rail_delay_time <= d;
    ext_enable_mode <= ext;
    src_fail <= fail;
    supply_ok <= 1'b1;
    enable_level <= 1'b0;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    wait_for(0, 1'b1, n);
  endtask : start
  // ==========================================================
  // scenarios
  task automatic sc_normal();
    logic [7:0] c;
    start(16'h0005, 16'h0003, 1'b0, 1'b0);
    check_bit(ctrl.panel_reset_n_oe & ~ctrl.panel_reset_n_out, 1'b1, "reset not held");
    check_bit(ctrl.neg_pump_enable, 1'b0, "gate-low rail before logic");
    wait_for(1, 1'b1, t1);
    check_bit(ctrl.panel_reset_n_oe, 1'b0, "reset not released with pump");
    check_bit(ctrl.boost_enable, 1'b0, "boost too early");
    wait_for(2, 1'b0, n);
    check_num(n, 3, "rail delay length");
    check_bit(ctrl.pos_pump_short_mode, 1'b1, "short mode late");
    repeat (10) @(posedge ref_clk);
    #1;
    check_bit(ctrl.pos_pump_current_off, 1'b1, "pump current still on");
    wait_for(3, 1'b1, n);
    check_num(n, 6, "source check moment");
    check_bit(ctrl.pos_pump_normal, 1'b1, "pump not normal");
    c = ctrl.positive_pump_control;
    @(posedge ref_clk);
    #1;
    check_bit(ctrl.positive_pump_control === c + 8'h01, 1'b1, "ramp step");
    repeat (260) @(posedge ref_clk);
    #1;
    check_bit(ctrl.positive_pump_control === 8'hFF, 1'b1, "ramp end");
  endtask : sc_normal
  task automatic sc_pulse();
    start(16'h0009, 16'h0003, 1'b0, 1'b0);
    wait_for(1, 1'b1, n);
    check_num(n - t1, 4, "pulse length step");
    start(16'h0000, 16'h0000, 1'b0, 1'b0);
    wait_for(1, 1'b1, n);
    check_num(t1 - n, 4, "zero pulse not short");
    wait_for(2, 1'b0, n);
    check_num(n, 1, "zero delay");
    wait_for(3, 1'b1, n);
  endtask : sc_pulse
  task automatic sc_fault();
    start(16'h0005, 16'h0003, 1'b0, 1'b1);
    wait_for(2, 1'b0, n);
    wait_for(4, 1'b1, n);
    check_num(n, 16, "error moment");
    repeat (40) @(posedge ref_clk);
    #1;
    check_bit(ctrl.boost_enable, 1'b0, "boost after error");
  endtask : sc_fault
  task automatic sc_inhibit();
    start(16'h0005, 16'h0003, 1'b0, 1'b0);
    wait_for(3, 1'b1, n);
    @(posedge ref_clk);
    supply_ok <= 1'b0;
    wait_for(0, 1'b0, n);
    check_bit(ctrl.neg_pump_enable | ctrl.boost_enable | ~ctrl.isolation_gate_drive_n, 1'b0,
      "rails not off at once");
    repeat (20) @(posedge ref_clk);
    #1;
    check_bit(ctrl.buck_enable, 1'b0, "restart below uvlo");
    @(posedge ref_clk);
    supply_ok <= 1'b1;
    wait_for(0, 1'b1, n);
    @(posedge ref_clk);
    hot <= 1'b1;
    cool <= 1'b0;
    wait_for(0, 1'b0, n);
    check_bit(ctrl.thermal_shutdown, 1'b1, "thermal flag");
    @(posedge ref_clk);
    hot <= 1'b0;
    repeat (20) @(posedge ref_clk);
    #1;
    check_bit(ctrl.buck_enable, 1'b0, "resumed while warm");
    @(posedge ref_clk);
    cool <= 1'b1;
    wait_for(0, 1'b1, n);
    check_bit(ctrl.thermal_shutdown, 1'b0, "no resume when cool");
  endtask : sc_inhibit
  task automatic sc_ext();
    start(16'h0005, 16'h0003, 1'b1, 1'b0);
    repeat (40) @(posedge ref_clk);
    #1;
    check_bit(ctrl.panel_reset_n_oe & ~ctrl.neg_pump_enable, 1'b1, "ran without enable");
    @(posedge ref_clk);
    enable_level <= 1'b1;
    wait_for(1, 1'b1, n);
    check_bit(ctrl.panel_reset_n_oe, 1'b0, "reset held after enable");
    wait_for(3, 1'b1, n);
  endtask : sc_ext
  initial begin
    repeat (2) @(posedge ref_clk);
    sc_normal();
    sc_pulse();
    sc_fault();
    sc_inhibit();
    sc_ext();
    give_verdict();
  end
endmodule : tb_top
